// >>> pkg/ulms_params.svh
`ifndef ULMS_PARAMS_SVH
`define ULMS_PARAMS_SVH
// ****************************************
// Line condition flag bit positions
// ****************************************
`define ULMS_LCF_DR       0
`define ULMS_LCF_OE       1
`define ULMS_LCF_PE       2
`define ULMS_LCF_RST      8'h00
// ****************************************
// Handshake input flag bit positions
// ****************************************
`define ULMS_HIF_DCTS     0
`define ULMS_HIF_DDSR     1
`define ULMS_HIF_TERI     2
`define ULMS_HIF_DCD      3
`define ULMS_DELTA_RST    4'h0
`define ULMS_LVL_RST      4'hf
// ****************************************
// Handshake output control bit positions
// ****************************************
`define ULMS_HOC_DTR      0
`define ULMS_HOC_RTS      1
`define ULMS_HOC_OP1      2
`define ULMS_HOC_OP2      3
// ****************************************
// Timing
// ****************************************
`define ULMS_SETTLE       3
`endif

// >>> pkg/ulms_pkg.sv
package ulms_pkg;
    // Receive datapath event carrier
    typedef struct packed {
        logic done;
        logic parity_bad;
    } ulms_rx_evt_t;
    // Active-low modem pins, order matches flags 7..4
    typedef struct packed {
        logic carrier_detect_in_n;
        logic ring_indicator_in_n;
        logic dsr_n;
        logic cts_n;
    } ulms_modem_n_t;
    // Change detector state
    typedef enum logic [0:0] {
        ULMS_SETTLE,
        ULMS_RUN
    } ulms_state_t;
endpackage

// >>> rtl/ulms_status.sv
// Functional notes
// - Parity error flag; FIFO mode follows top
// - Overrun flag when char completes, FIFO full
// - Overrun character never pushed into FIFO
// - Data ready high while data held
// - Data ready low when nothing held
// - Change bits set on qualifying input change
// - Reading handshake flags clears change bits
// - Bits 7..4 show inverted modem pins
// - Loop-back: bit7 op2, bit6 op1
// - Loop-back: bit5 dtr, bit4 rts
// - Bits 3,1,0 set on either-direction change
// - Bit 2 set only on ring trailing edge
// - Modem interrupt while any change bit set
// - Reset: change bits zero, levels bits 7..4 zero
// - Reset: line flags 4..0 zero
`timescale 1ns/1ps
`default_nettype none
`include "ulms_params.svh"

module ulms_status #(
    parameter int SETTLE_CYCLES = `ULMS_SETTLE
) (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst,
    // Receive datapath, same clock
    input  wire ulms_pkg::ulms_rx_evt_t rx_evt,
    input  wire logic                   rx_fifo_full,
    input  wire logic                   rx_fifo_mode,
    input  wire logic                   rx_top_parity_err,
    input  wire logic                   rx_data_avail,
    output logic                        rx_push,
    // Modem pins, asynchronous
    input  wire ulms_pkg::ulms_modem_n_t modem_n,
    // Control from the modem control register
    input  wire logic [3:0]             handshake_output_control,
    input  wire logic                   loop_mode,
    // Host read strobes and read data
    input  wire logic                   lcf_read,
    input  wire logic                   hif_read,
    output logic [7:0]                  line_condition_flags,
    output logic [7:0]                  handshake_input_flags,
    output logic                        modem_irq
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    // Fewer than 4 cycles let the sync chain's reset value look like an edge; this check rejects only values below 3
    if (SETTLE_CYCLES < 3 || SETTLE_CYCLES > 15) begin : g_bad_settle
        $error("SETTLE_CYCLES must lie in 3..15");
    end

    // ****************************************
    // Line condition flags
    // ****************************************
    logic pe_r, pe_nxt;
    logic oe_r, oe_nxt;
    logic dr_r, dr_nxt;

    // Character is handed to the FIFO only when there is room
    assign rx_push = rx_evt.done && !rx_fifo_full;

    // Next flags; a new event beats a clearing read
    always_comb begin
        if (rx_fifo_mode) begin
            pe_nxt = rx_top_parity_err;
        end else if (rx_evt.done && rx_evt.parity_bad) begin
            pe_nxt = 1'b1;
        end else if (lcf_read) begin
            pe_nxt = 1'b0;
        end else begin
            pe_nxt = pe_r;
        end
        if (rx_evt.done && rx_fifo_full) begin
            oe_nxt = 1'b1;
        end else if (lcf_read) begin
            oe_nxt = 1'b0;
        end else begin
            oe_nxt = oe_r;
        end
        dr_nxt = rx_data_avail;
    end

    // Register the flags
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pe_r <= 1'b0;
            oe_r <= 1'b0;
            dr_r <= 1'b0;
        end else begin
            pe_r <= pe_nxt;
            oe_r <= oe_nxt;
            dr_r <= dr_nxt;
        end
    end

    // Upper bits belong to other blocks and read as zero here
    always_comb begin
        line_condition_flags = `ULMS_LCF_RST;
        line_condition_flags[`ULMS_LCF_PE] = pe_r;
        line_condition_flags[`ULMS_LCF_OE] = oe_r;
        line_condition_flags[`ULMS_LCF_DR] = dr_r;
    end

    // ****************************************
    // Modem pin synchronisers
    // ****************************************
    logic [3:0] pin_n;
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] lvl_r, lvl_nxt;

    assign pin_n = modem_n;

    // Three stages per pin; first stage feeds only the second
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                s1_r[i] <= 1'b1;
                s2_r[i] <= 1'b1;
                s3_r[i] <= 1'b1;
            end else begin
                s1_r[i] <= pin_n[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
            end
        end
        // Level moves only once two late stages agree
        always_comb begin
            lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
        end
    end

    // Register filtered levels
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lvl_r <= `ULMS_LVL_RST;
        end else begin
            lvl_r <= lvl_nxt;
        end
    end

    // ****************************************
    // Handshake input flags
    // ****************************************
    localparam int CW = 4;
    ulms_pkg::ulms_state_t st_r, st_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [3:0]    up_r, up_nxt;
    logic [3:0]    loop_map;
    logic [3:0]    delta_set;
    logic [3:0]    delta_r, delta_nxt;

    // Loop-back returns the control outputs instead of the pins
    assign loop_map = {handshake_output_control[`ULMS_HOC_OP2],
                       handshake_output_control[`ULMS_HOC_OP1],
                       handshake_output_control[`ULMS_HOC_DTR],
                       handshake_output_control[`ULMS_HOC_RTS]};

    // Settle after reset; the chain's fill counts as a change unless SETTLE_CYCLES is 4 or more
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            ulms_pkg::ULMS_SETTLE: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == CW'(SETTLE_CYCLES)) begin
                    st_nxt = ulms_pkg::ULMS_RUN;
                end
            end
            ulms_pkg::ULMS_RUN: begin
                cnt_nxt = cnt_r;
            end
            default: begin
                st_nxt = ulms_pkg::ULMS_SETTLE;
            end
        endcase
    end

    // Levels, edge qualification and sticky change bits
    always_comb begin
        up_nxt = loop_mode ? loop_map : ~lvl_r;
        delta_set[3] = up_nxt[3] ^ up_r[3];
        delta_set[2] = up_r[2] && !up_nxt[2];
        delta_set[1] = up_nxt[1] ^ up_r[1];
        delta_set[0] = up_nxt[0] ^ up_r[0];
        if (st_r != ulms_pkg::ULMS_RUN) begin
            delta_set = 4'h0;
        end
        // Set wins over the clearing read
        delta_nxt = (hif_read ? 4'h0 : delta_r) | delta_set;
    end

    // Register the handshake state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r    <= ulms_pkg::ULMS_SETTLE;
            cnt_r   <= '0;
            up_r    <= ~`ULMS_LVL_RST;
            delta_r <= `ULMS_DELTA_RST;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            up_r    <= up_nxt;
            delta_r <= delta_nxt;
        end
    end

    assign handshake_input_flags = {up_r, delta_r};
    // Level interrupt, drops only when every change bit is read away
    assign modem_irq = |delta_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence ri_trail_s;
        !loop_mode ##1 !loop_mode && $rose(lvl_r[2]);
    endsequence

    sequence ri_lead_s;
        !loop_mode ##1 !loop_mode && $fell(lvl_r[2]) && !delta_r[2];
    endsequence

    sequence cd_change_s;
        !loop_mode ##1 !loop_mode && $changed(lvl_r[3]);
    endsequence

    pe_fifo_a: assert property (rx_fifo_mode |=> pe_r == $past(rx_top_parity_err))
        else $error("parity flag not following FIFO top");
    pe_set_a: assert property (!rx_fifo_mode && rx_evt.done && rx_evt.parity_bad |=> pe_r)
        else $error("parity flag not set");
    oe_set_a: assert property (rx_evt.done && rx_fifo_full |=> oe_r ##0 $past(!rx_push))
        else $error("overrun flag not set");
    no_push_a: assert property (rx_fifo_full |-> !rx_push)
        else $error("push into full FIFO");
    dr_follow_a: assert property (##1 dr_r == $past(rx_data_avail))
        else $error("data ready wrong");
    dr_low_a: assert property (!rx_data_avail ##1 !rx_data_avail |-> !dr_r)
        else $error("data ready high with no data");
    ri_trail_a: assert property (st_r == ulms_pkg::ULMS_RUN ##0 ri_trail_s |=> delta_r[2])
        else $error("ring trailing edge missed");
    ri_lead_a: assert property (st_r == ulms_pkg::ULMS_RUN ##0 ri_lead_s |=> !delta_r[2])
        else $error("ring leading edge set change bit");
    cd_irq_a: assert property (st_r == ulms_pkg::ULMS_RUN ##0 cd_change_s
                               |=> delta_r[3] && modem_irq)
        else $error("carrier change missed");
    read_clr_a: assert property (hif_read && delta_set == 4'h0 |=> delta_r == 4'h0)
        else $error("read did not clear change bits");
    set_wins_a: assert property (hif_read && delta_set[0] |=> delta_r[0] && modem_irq)
        else $error("change lost on clearing read");
    loop_map_a: assert property (loop_mode |=> up_r == $past(loop_map))
        else $error("loop-back mapping wrong");
    normal_a: assert property (!loop_mode |=> up_r == ~$past(lvl_r))
        else $error("inverted pin level wrong");
    settle_a: assert property (st_r == ulms_pkg::ULMS_SETTLE |-> delta_r == 4'h0)
        else $error("change bit during settle");

endmodule // ulms_status

`default_nettype wire

// >>> dv/ulms_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Modem side of the handshake pins
// ****************************************
module ulms_modem_model (
    // Clock used only to place pin changes
    input  wire logic                    clock,
    // Active-low handshake pins toward the device
    output wire ulms_pkg::ulms_modem_n_t modem_n
);
    logic [3:0] pins_r = 4'hf;  // Idle: every pin inactive
    assign modem_n = ulms_pkg::ulms_modem_n_t'(pins_r);
    // Change one pin off the sampling edge and hold it long enough for the input filter
    task automatic set_pin(input int idx, input logic level);
        @(negedge clock);
        pins_r[idx] = level;
        repeat (3) @(negedge clock);
    endtask
endmodule // ulms_modem_model
`default_nettype wire

// >>> dv/test_uart_line_modem_status.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Self-checking bench for the status block
// ****************************************
module test_uart_line_modem_status;
    typedef struct { int kind; logic [7:0] exp; logic [7:0] mask; } ulms_note_t;
    logic                    clock;
    logic                    rst;
    ulms_pkg::ulms_rx_evt_t  rx_evt;
    logic                    rx_fifo_full, rx_fifo_mode, rx_top_parity_err, rx_data_avail;
    logic [3:0]              hoc;
    logic                    loop_mode, lcf_read, hif_read;
    wire logic               rx_push, modem_irq;
    wire logic [7:0]         lcf, hif;
    wire ulms_pkg::ulms_modem_n_t modem_n;
    ulms_note_t              notes[$];
    event                    sample_ev;
    int                      mismatches = 0;
    int                      comparisons = 0;
    int                      cycles = 0;
    string names[4] = '{"line_condition_flags", "handshake_input_flags", "modem_irq", "rx_push"};

    ulms_modem_model modem (.clock(clock), .modem_n(modem_n));
    ulms_status #(.SETTLE_CYCLES(3)) dut (
        .clock(clock), .rst(rst), .rx_evt(rx_evt), .rx_fifo_full(rx_fifo_full),
        .rx_fifo_mode(rx_fifo_mode), .rx_top_parity_err(rx_top_parity_err),
        .rx_data_avail(rx_data_avail), .rx_push(rx_push), .modem_n(modem_n),
        .handshake_output_control(hoc), .loop_mode(loop_mode), .lcf_read(lcf_read),
        .hif_read(hif_read), .line_condition_flags(lcf), .handshake_input_flags(hif),
        .modem_irq(modem_irq));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic put(input int kind, input logic [7:0] exp, input logic [7:0] mask);
        notes.push_back('{kind, exp, mask});
    endtask
    // Mark a check point; drives stay on the falling edge, the watcher looks later
    task automatic sample();
        -> sample_ev;
    endtask
    task automatic read_hif();
        hif_read = 1'b1;
        @(negedge clock);
        hif_read = 1'b0;
        @(negedge clock);
    endtask
    // Watcher: every sample point retires all pending notes, oldest first
    initial forever begin
        @(sample_ev);
        #1; // Let combinational outputs settle after the falling-edge drive
        while (notes.size() > 0) begin
            ulms_note_t n;
            logic [7:0] seen;
            n = notes.pop_front();
            seen = (n.kind == 0) ? lcf : (n.kind == 1) ? hif :
                   (n.kind == 2) ? {7'h00, modem_irq} : {7'h00, rx_push};
            comparisons++;
            if ((seen & n.mask) !== n.exp) begin
                mismatches++;
                $display("Error %s expected %h seen %h", names[n.kind], n.exp, seen & n.mask);
            end
        end
    end

    initial begin
        logic [3:0] pins_e;
        logic [3:0] d;
        logic       pb;
        void'($urandom(80));
        {rst, rx_fifo_full, rx_fifo_mode, rx_top_parity_err, rx_data_avail} = 5'h10;
        {loop_mode, lcf_read, hif_read} = 3'h0;
        rx_evt = '0;
        hoc = 4'h0;
        pins_e = 4'hf;
        repeat (3) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        repeat (8) @(negedge clock);
        put(0, 8'h00, 8'hff);
        put(1, 8'h00, 8'hff);
        sample();
        // Each pin goes active then back idle; the ring pin counts only its release
        for (int i = 0; i < 4; i++) for (int v = 0; v < 2; v++) begin
            pins_e[i] = v[0];
            modem.set_pin(i, v[0]);
            repeat (5) @(negedge clock);
            d = (i == 2 && v == 0) ? 4'h0 : 4'h1 << i;
            put(1, {~pins_e, d}, 8'hff);
            put(2, {7'h00, |d}, 8'h01);
            sample();
            read_hif();
            put(1, {~pins_e, 4'h0}, 8'hff);
            put(2, 8'h00, 8'h01);
            sample();
        end
        // A change landing on the clearing read's edge must survive the read
        pins_e[0] = 1'b0;
        modem.set_pin(0, 1'b0);
        @(negedge clock);
        read_hif();
        put(1, {~pins_e, 4'h1}, 8'hff);
        put(2, 8'h01, 8'h01);
        sample();
        pins_e[0] = 1'b1;
        modem.set_pin(0, 1'b1);
        repeat (5) @(negedge clock);
        read_hif();
        // Loop-back: change bits may fire on the switch, so only levels are compared
        loop_mode = 1'b1;
        for (int k = 0; k < 4; k++) begin
            hoc = 4'($urandom());
            repeat (8) @(negedge clock);
            put(1, {hoc[3], hoc[2], hoc[0], hoc[1], 4'h0}, 8'hf0);
            sample();
        end
        loop_mode = 1'b0;
        repeat (8) @(negedge clock);
        read_hif();
        // Character events with and without a full FIFO, then a clearing read
        for (int k = 0; k < 4; k++) begin
            pb = 1'($urandom());
            @(negedge clock);
            rx_evt.done = 1'b1;
            rx_evt.parity_bad = pb;
            rx_fifo_full = k[0];
            rx_data_avail = k[1];
            put(3, {7'h00, ~k[0]}, 8'h01);
            sample();
            @(negedge clock);
            rx_evt = '0;
            put(0, {5'h00, pb, k[0], k[1]}, 8'hff);
            sample();
            lcf_read = 1'b1;
            @(negedge clock);
            lcf_read = 1'b0;
            @(negedge clock);
            put(0, {7'h00, k[1]}, 8'hff);
            sample();
        end
        // FIFO mode: parity flag follows the top character and survives a read
        rx_fifo_mode = 1'b1;
        for (int v = 1; v >= 0; v--) begin
            rx_top_parity_err = v[0];
            lcf_read = 1'b1;
            @(negedge clock);
            lcf_read = 1'b0;
            @(negedge clock);
            put(0, {5'h00, v[0], 2'h0}, 8'h04);
            sample();
        end
        @(negedge clock);
        wrap_up();
    end
endmodule // test_uart_line_modem_status
`default_nettype wire
